// >>> bench/icpb_assertions.sv
`timescale 1ns/100ps
// watches the bus and the pending flags at the top level
module icpb_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // lines and core side
  input wire logic        dma_line,
  input wire logic [15:0] pending_lines,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // writes count only with both live lanes enabled, as disabled lanes do nothing
  logic acc_w;
  logic wr_clr;
  logic wr_set;
  logic rd_clr;
  assign acc_w  = psel && penable && pwrite && pstrb[1:0] == 2'b11;
  assign wr_clr = acc_w && paddr == icpb_pkg::OFS_CLR_PEND;
  assign wr_set = acc_w && paddr == icpb_pkg::OFS_SET_PEND;
  assign rd_clr = psel && !penable && !pwrite && paddr == icpb_pkg::OFS_CLR_PEND;

  a_clear_one_drops: assert property (
    wr_clr && pwdata[15] && !dma_line |=> !pending_lines[15])
    else $error("bit 15 still pending after a clear");
  a_clear_stays_off: assert property (
    wr_clr && pwdata[15] && !dma_line ##1 !dma_line |=> !pending_lines[15])
    else $error("bit 15 came back with its line quiet");
  a_zero_keeps: assert property (
    wr_clr && !pwdata[15] && pending_lines[15] |=> pending_lines[15])
    else $error("a zero write cleared bit 15");
  a_read_shows: assert property (rd_clr |=> prdata == {16'h0000, $past(pending_lines)})
    else $error("clear view differs from pending flags");
  a_set_marks: assert property (
    wr_set |=> ({16'h0000, pending_lines} & $past(pwdata)) == ($past(pwdata) & 32'h0000_FFFF))
    else $error("set write left a line not pending");
  a_line_pends: assert property ($rose(dma_line) |=> pending_lines[15])
    else $error("raised line 15 did not pend");
  a_upper_quiet: assert property (prdata[31:16] == 16'h0000)
    else $error("reserved half reads nonzero");
  a_reset_clean: assert property ($rose(rst_n) |-> pending_lines == 16'h0000 && !irq)
    else $error("state not clear after reset");
  a_misaligned_err: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access without error");
endmodule

bind icpb_top icpb_assertions icpb_assertions_i (.clk_sys, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pslverr, .dma_line, .pending_lines, .irq);

// >>> bench/icpb_line_src.sv
`timescale 1ns/100ps
// peripheral sources: a request bit becomes a line pulse launched on an edge,
// so lines never move between edges, just like a real synchronous source
module icpb_line_src (
  // clock
  input  wire logic        clk_sys,
  // requests from the bench, register bit order
  input  wire logic [15:0] fire,
  // lines towards the block
  output logic      [15:0] lines
);
  always_ff @(posedge clk_sys) begin
    lines <= fire;
  end
endmodule

// >>> bench/icpb_tb.sv
`timescale 1ns/100ps
module icpb_tb;
  localparam logic [11:0] clr_a = icpb_pkg::OFS_CLR_PEND;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hF;
  logic [15:0] fire    = 16'h0000;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        irq;
  logic [15:0] ln;
  logic [15:0] pending_lines;
  int          err_total = 0;
  int          compares  = 0;

  always #20 clk_sys = ~clk_sys;

  icpb_line_src icpb_line_src_i (.clk_sys(clk_sys), .fire(fire), .lines(ln));
  // line wiring follows the register bit positions
  icpb_top icpb_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_line(ln[15]), .bridge_driver_line(ln[14]),
    .external_line_one(ln[13]), .external_line_zero(ln[12]),
    .async_serial_two_line(ln[11]), .async_serial_one_line(ln[10]),
    .sync_serial_two_line(ln[9]), .sync_serial_one_line(ln[8]),
    .capcom_request_three_line(ln[7]), .capcom_request_two_line(ln[6]),
    .capcom_request_one_line(ln[5]), .capcom_request_zero_line(ln[4]),
    .converter_one_line(ln[3]), .converter_two_line(ln[2]),
    .gp_timer_two_line(ln[1]), .gp_timer_one_line(ln[0]),
    .pending_lines(pending_lines), .irq(irq));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // one-cycle line pulse; returns once the flag has landed
  task pulse(input logic [15:0] m);
    @(posedge clk_sys);
    fire <= m;
    @(posedge clk_sys);
    fire <= 16'h0000;
    repeat (2) @(posedge clk_sys);
  endtask

  task t_reset;
    rd_chk(clr_a, 32'h0000_0000);
    chk({16'h0000, pending_lines}, 32'h0000_0000);
    chk({31'h0, pready}, 32'h0000_0001);
    $display("reset test done");
  endtask

  // each line alone: zero write on its bit with ones elsewhere, then a one
  task t_lines;
    for (int i = 0; i < 16; i++) begin
      pulse(16'h0001 << i);
      rd_chk(clr_a, 32'h0000_0001 << i);
      apb(1'b1, clr_a, ~(32'h0000_0001 << i));
      rd_chk(clr_a, 32'h0000_0001 << i);
      apb(1'b1, clr_a, 32'h0000_0001 << i);
      rd_chk(clr_a, 32'h0000_0000);
    end
    $display("lines test done");
  endtask

  task t_soft;
    apb(1'b1, icpb_pkg::OFS_SET_PEND, 32'hFFFF_FFFF);
    rd_chk(clr_a, 32'h0000_FFFF);
    apb(1'b1, clr_a, 32'hFFFF_0000);
    rd_chk(clr_a, 32'h0000_FFFF);
    pstrb <= 4'hC;
    apb(1'b1, clr_a, 32'h0000_FFFF);
    pstrb <= 4'hF;
    rd_chk(clr_a, 32'h0000_FFFF);
    apb(1'b1, clr_a, 32'h0000_A5A5);
    rd_chk(clr_a, 32'h0000_5A5A);
    chk({16'h0000, pending_lines}, 32'h0000_5A5A);
    apb(1'b1, clr_a, 32'h0000_FFFF);
    $display("soft test done");
  endtask

  // irq is registered, so each check after a mask or status write lets one edge pass
  task t_irq;
    apb(1'b1, icpb_pkg::OFS_EVT_STATUS, 32'h0000_FFFF);
    apb(1'b1, icpb_pkg::OFS_EVT_MASK, 32'h0000_0001);
    pulse(16'h0001);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, icpb_pkg::OFS_EVT_MASK, 32'h0000_0000);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, icpb_pkg::OFS_EVT_MASK, 32'h0000_0001);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, icpb_pkg::OFS_EVT_STATUS, 32'h0000_0001);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(clr_a, 32'h0000_0001);
    $display("irq test done");
  endtask

  task t_bad;
    rd_chk(12'h284, 32'h0000_0000);
    chk({31'h0, serr}, 32'h0000_0001);
    apb(1'b1, 12'h281, 32'h0000_FFFF);
    chk({31'h0, serr}, 32'h0000_0001);
    rd_chk(clr_a, 32'h0000_0001);
    $display("unmapped test done");
  endtask

  // line 0 held high: edge mode pends once, level mode re-pends and beats a clear
  task t_mode;
    apb(1'b1, clr_a, 32'h0000_FFFF);
    apb(1'b1, icpb_pkg::OFS_TRIG_MODE, 32'h0000_0001);
    fire <= 16'h0001;
    repeat (3) @(posedge clk_sys);
    rd_chk(clr_a, 32'h0000_0001);
    apb(1'b1, clr_a, 32'h0000_0001);
    rd_chk(clr_a, 32'h0000_0000);
    apb(1'b1, icpb_pkg::OFS_TRIG_MODE, 32'h0000_0000);
    rd_chk(clr_a, 32'h0000_0001);
    apb(1'b1, clr_a, 32'h0000_0001);
    rd_chk(clr_a, 32'h0000_0001);
    rd_chk(icpb_pkg::OFS_OVERFLOW, 32'h0000_0001);
    rd_chk(icpb_pkg::OFS_SUMMARY, 32'h0000_8001);
    rd_chk(icpb_pkg::OFS_EVT_MASK, 32'h0000_0001);
    rd_chk(icpb_pkg::OFS_TRIG_MODE, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    fire <= 16'h0000;
    repeat (2) @(posedge clk_sys);
    apb(1'b1, clr_a, 32'h0000_0001);
    apb(1'b1, icpb_pkg::OFS_OVERFLOW, 32'h0000_0001);
    rd_chk(icpb_pkg::OFS_OVERFLOW, 32'h0000_0000);
    rd_chk(icpb_pkg::OFS_SUMMARY, 32'h0000_0000);
    rd_chk(clr_a, 32'h0000_0000);
    $display("mode test done");
  endtask

  task complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_lines;
    t_soft;
    t_irq;
    t_bad;
    t_mode;
    complete_run;
  end

  // whole run is near 430 cycles; this allows over eighteen times that
  initial begin
    #320000;
    err_total++;
    complete_run;
  end
endmodule

// >>> verilog/icpb_apb_decode.sv
`timescale 1ns/100ps
// address decode for the register window; misaligned words are unmapped
module icpb_apb_decode (
  // bus address
  input  wire logic [11:0] paddr,
  // selects
  output logic             sel_set,
  output logic             sel_clr,
  output logic             sel_evt,
  output logic             sel_mask,
  output logic             sel_mode,
  output logic             sel_sum,
  output logic             sel_ovf,
  output logic             hit
);

  // one-hot selects from a full compare of the byte address
  always_comb begin
    sel_set  = (paddr == icpb_pkg::OFS_SET_PEND);
    sel_clr  = (paddr == icpb_pkg::OFS_CLR_PEND);
    sel_evt  = (paddr == icpb_pkg::OFS_EVT_STATUS);
    sel_mask = (paddr == icpb_pkg::OFS_EVT_MASK);
    sel_mode = (paddr == icpb_pkg::OFS_TRIG_MODE);
    sel_sum  = (paddr == icpb_pkg::OFS_SUMMARY);
    sel_ovf  = (paddr == icpb_pkg::OFS_OVERFLOW);
    hit      = sel_set | sel_clr | sel_evt | sel_mask | sel_mode | sel_sum | sel_ovf;
  end

endmodule

// >>> verilog/icpb_pend_cell.sv
`timescale 1ns/100ps
// one pending flag; any set request beats a clear in the same cycle
module icpb_pend_cell (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // requests
  input  wire logic set_hw,
  input  wire logic set_sw,
  input  wire logic clr_sw,
  // state
  output logic      pending
);

  logic pending_reg;
  logic pending_next;

  // clear only removes the old state, so a set arriving now survives
  always_comb begin
    pending_next = (pending_reg & ~clr_sw) | set_hw | set_sw;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;

endmodule

// >>> verilog/icpb_pkg.sv
package icpb_pkg;

  // geometry
  localparam int unsigned NUM_LINES  = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;

  // register byte offsets
  localparam logic [11:0] OFS_SET_PEND   = 12'h200;
  localparam logic [11:0] OFS_CLR_PEND   = 12'h280;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h400;
  localparam logic [11:0] OFS_EVT_MASK   = 12'h404;
  localparam logic [11:0] OFS_TRIG_MODE  = 12'h408;
  localparam logic [11:0] OFS_SUMMARY    = 12'h40C;
  localparam logic [11:0] OFS_OVERFLOW   = 12'h410;

  // bit positions of the interrupt lines in every line-shaped register
  localparam int unsigned BIT_DMA_LINE         = 15;
  localparam int unsigned BIT_BRIDGE_DRIVER    = 14;
  localparam int unsigned BIT_EXTERNAL_ONE     = 13;
  localparam int unsigned BIT_EXTERNAL_ZERO    = 12;
  localparam int unsigned BIT_ASYNC_SERIAL_TWO = 11;
  localparam int unsigned BIT_ASYNC_SERIAL_ONE = 10;
  localparam int unsigned BIT_SYNC_SERIAL_TWO  = 9;
  localparam int unsigned BIT_SYNC_SERIAL_ONE  = 8;
  localparam int unsigned BIT_CAPCOM_THREE     = 7;
  localparam int unsigned BIT_CAPCOM_ZERO      = 4;
  localparam int unsigned BIT_CONVERTER_ONE    = 3;
  localparam int unsigned BIT_CONVERTER_TWO    = 2;
  localparam int unsigned BIT_GP_TIMER_TWO     = 1;
  localparam int unsigned BIT_GP_TIMER_ONE     = 0;

  // summary register fields
  localparam int unsigned SUM_COUNT_LSB   = 0;
  localparam int unsigned SUM_HIGHEST_LSB = 8;
  localparam int unsigned SUM_ANY_BIT     = 15;

  // values after reset
  localparam logic [15:0] RST_PENDING  = 16'h0000;
  localparam logic [15:0] RST_EVT      = 16'h0000;
  localparam logic [15:0] RST_MASK     = 16'h0000;
  localparam logic [15:0] RST_MODE     = 16'h0000;
  localparam logic [31:0] RST_PRDATA   = 32'h0000_0000;

endpackage

// >>> verilog/icpb_top.sv
`timescale 1ns/100ps
module icpb_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // peripheral interrupt lines, same clock domain
  input  wire logic        dma_line,
  input  wire logic        bridge_driver_line,
  input  wire logic        external_line_one,
  input  wire logic        external_line_zero,
  input  wire logic        async_serial_two_line,
  input  wire logic        async_serial_one_line,
  input  wire logic        sync_serial_two_line,
  input  wire logic        sync_serial_one_line,
  input  wire logic        capcom_request_three_line,
  input  wire logic        capcom_request_two_line,
  input  wire logic        capcom_request_one_line,
  input  wire logic        capcom_request_zero_line,
  input  wire logic        converter_one_line,
  input  wire logic        converter_two_line,
  input  wire logic        gp_timer_two_line,
  input  wire logic        gp_timer_one_line,
  // towards the core
  output logic      [15:0] pending_lines,
  output logic             irq
);

  localparam int unsigned N = icpb_pkg::NUM_LINES;

  // line vector and its edge history
  logic [N-1:0] line_vec;
  logic [N-1:0] line_prev_reg;
  logic [N-1:0] line_prev_next;
  logic [N-1:0] hw_set;

  // pending state
  logic [N-1:0] pending;

  // software write strobes per line
  logic [N-1:0] sw_set;
  logic [N-1:0] sw_clr;
  logic [N-1:0] evt_clr;
  logic [N-1:0] ovf_clr;

  // control and status registers
  logic [N-1:0] evt_status_reg;
  logic [N-1:0] evt_status_next;
  logic [N-1:0] evt_mask_reg;
  logic [N-1:0] evt_mask_next;
  logic [N-1:0] trig_mode_reg;
  logic [N-1:0] trig_mode_next;
  logic [N-1:0] overflow_reg;
  logic [N-1:0] overflow_next;
  logic         irq_reg;
  logic         irq_next;

  // bus side
  logic         sel_set;
  logic         sel_clr;
  logic         sel_evt;
  logic         sel_mask;
  logic         sel_mode;
  logic         sel_sum;
  logic         sel_ovf;
  logic         hit;
  logic         setup_rd;
  logic         acc_wr;
  logic [N-1:0] wr_lanes;
  logic [N-1:0] wr_bits;
  logic [31:0]  rd_mux;
  logic [31:0]  prdata_reg;
  logic [31:0]  prdata_next;
  logic [15:0]  summary;

  // fixed bit placement of every source line
  always_comb begin
    line_vec = '0;
    line_vec[icpb_pkg::BIT_DMA_LINE]         = dma_line;
    line_vec[icpb_pkg::BIT_BRIDGE_DRIVER]    = bridge_driver_line;
    line_vec[icpb_pkg::BIT_EXTERNAL_ONE]     = external_line_one;
    line_vec[icpb_pkg::BIT_EXTERNAL_ZERO]    = external_line_zero;
    line_vec[icpb_pkg::BIT_ASYNC_SERIAL_TWO] = async_serial_two_line;
    line_vec[icpb_pkg::BIT_ASYNC_SERIAL_ONE] = async_serial_one_line;
    line_vec[icpb_pkg::BIT_SYNC_SERIAL_TWO]  = sync_serial_two_line;
    line_vec[icpb_pkg::BIT_SYNC_SERIAL_ONE]  = sync_serial_one_line;
    line_vec[icpb_pkg::BIT_CAPCOM_THREE]     = capcom_request_three_line;
    line_vec[icpb_pkg::BIT_CAPCOM_ZERO + 2]  = capcom_request_two_line;
    line_vec[icpb_pkg::BIT_CAPCOM_ZERO + 1]  = capcom_request_one_line;
    line_vec[icpb_pkg::BIT_CAPCOM_ZERO]      = capcom_request_zero_line;
    line_vec[icpb_pkg::BIT_CONVERTER_ONE]    = converter_one_line;
    line_vec[icpb_pkg::BIT_CONVERTER_TWO]    = converter_two_line;
    line_vec[icpb_pkg::BIT_GP_TIMER_TWO]     = gp_timer_two_line;
    line_vec[icpb_pkg::BIT_GP_TIMER_ONE]     = gp_timer_one_line;
  end

  // address decode
  icpb_apb_decode u_decode (
    .paddr    (paddr),
    .sel_set  (sel_set),
    .sel_clr  (sel_clr),
    .sel_evt  (sel_evt),
    .sel_mask (sel_mask),
    .sel_mode (sel_mode),
    .sel_sum  (sel_sum),
    .sel_ovf  (sel_ovf),
    .hit      (hit)
  );

  // a write lands only at the access edge; strobes gate the two low byte lanes
  always_comb begin
    setup_rd = psel & ~penable & ~pwrite;
    acc_wr   = psel & penable & pwrite & hit;
    wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wr_bits  = pwdata[N-1:0] & wr_lanes;
  end

  // per-line software strobes; a zero bit never produces a strobe
  always_comb begin
    sw_set  = (acc_wr && sel_set)  ? wr_bits : '0;
    sw_clr  = (acc_wr && sel_clr)  ? wr_bits : '0;
    evt_clr = (acc_wr && sel_evt)  ? wr_bits : '0;
    ovf_clr = (acc_wr && sel_ovf)  ? wr_bits : '0;
  end

  // level lines set while high, edge lines only on a rising edge
  always_comb begin
    line_prev_next = line_vec;
    hw_set         = line_vec & ~(trig_mode_reg & line_prev_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      line_prev_reg <= '0;
    end else begin
      line_prev_reg <= line_prev_next;
    end
  end

  // one pending flag per line
  generate
    for (genvar i = 0; i < N; i++) begin : g_line
      icpb_pend_cell u_cell (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set_hw  (hw_set[i]),
        .set_sw  (sw_set[i]),
        .clr_sw  (sw_clr[i]),
        .pending (pending[i])
      );
    end
  endgenerate

  // events: a line newly becoming pending; overflow: a hardware request
  // landing on a line that is already pending, so one request is merged
  always_comb begin
    evt_status_next = (evt_status_reg & ~evt_clr) | ((hw_set | sw_set) & ~pending);
    overflow_next   = (overflow_reg & ~ovf_clr) | (hw_set & pending);
    evt_mask_next   = evt_mask_reg;
    trig_mode_next  = trig_mode_reg;
    if (acc_wr && sel_mask) begin
      evt_mask_next = (evt_mask_reg & ~wr_lanes) | wr_bits;
    end
    if (acc_wr && sel_mode) begin
      trig_mode_next = (trig_mode_reg & ~wr_lanes) | wr_bits;
    end
    // computed from next values so irq tracks status at the same edge
    irq_next = |(evt_status_next & evt_mask_next);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_status_reg <= icpb_pkg::RST_EVT;
      overflow_reg   <= icpb_pkg::RST_EVT;
      evt_mask_reg   <= icpb_pkg::RST_MASK;
      trig_mode_reg  <= icpb_pkg::RST_MODE;
      irq_reg        <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      overflow_reg   <= overflow_next;
      evt_mask_reg   <= evt_mask_next;
      trig_mode_reg  <= trig_mode_next;
      irq_reg        <= irq_next;
    end
  end

  // summary: count of pending lines, highest pending index, any flag
  always_comb begin
    logic [4:0] cnt;
    logic [4:0] top;
    cnt = 5'h00;
    top = 5'h00;
    for (int unsigned j = 0; j < N; j++) begin
      if (pending[j]) begin
        cnt = cnt + 5'h01;
        top = 5'(j);
      end
    end
    summary = 16'h0000;
    summary[icpb_pkg::SUM_COUNT_LSB +: 5]   = cnt;
    summary[icpb_pkg::SUM_HIGHEST_LSB +: 5] = top;
    summary[icpb_pkg::SUM_ANY_BIT]          = |pending;
  end

  // read mux; upper half of every register is zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      sel_set:  rd_mux[N-1:0] = pending;
      sel_clr:  rd_mux[N-1:0] = pending;
      sel_evt:  rd_mux[N-1:0] = evt_status_reg;
      sel_mask: rd_mux[N-1:0] = evt_mask_reg;
      sel_mode: rd_mux[N-1:0] = trig_mode_reg;
      sel_sum:  rd_mux[N-1:0] = summary;
      sel_ovf:  rd_mux[N-1:0] = overflow_reg;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle so prdata comes from a flop;
  // the value shows state as of the setup edge, one cycle before the access
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_reg <= icpb_pkg::RST_PRDATA;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // zero-wait access; unmapped addresses answer with an error
  always_comb begin
    pready  = 1'b1;
    pslverr = psel & penable & ~hit;
  end

  assign prdata        = prdata_reg;
  assign pending_lines = pending;
  assign irq           = irq_reg;

endmodule
